// File: tcs_timer_counter_set.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
module tcs_timer_counter_set import tcs_pkg::*; #(
  parameter int ADDR_W = TCS_ADDR_W
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // external pins
  input wire logic unit0_count_pin_in,
  input wire logic unit1_count_pin_in,
  input wire logic ctr2_count_pin_in,
  input wire logic trigger_pin_in,
  input wire logic [1:0] external_gate_pin_in,
  // interrupt serviced pulses for units zero and one
  input wire logic [1:0] unit_int_ack_in,
  // flags
  output logic [1:0] unit_overflow_flag_out,
  output logic ctr2_overflow_flag_out,
  output logic external_event_flag_out
);

  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic c3;
  logic c4;
  logic slow_tick;
  logic fast_tick;
  logic [TCS_NPINS-1:0] fall;

  logic [7:0] unit_control_register_ff;
  logic [7:0] unit_mode_register_ff;
  logic [7:0] clock_select_register_ff;
  logic [7:0] ctr2_control_register_ff;
  logic [7:0] ctr2_mode_register_ff;
  logic [7:0] u0_lo_ff;
  logic [7:0] u0_hi_ff;
  logic [7:0] u1_lo_ff;
  logic [7:0] u1_hi_ff;
  logic [15:0] ctr2_cnt_ff;
  logic [15:0] capture_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  tcs_unit_cfg_t cfg0;
  tcs_unit_cfg_t cfg1;
  tcs_cnt_t nxt_u0;
  tcs_cnt_t nxt_u1;
  logic nxt_u0_hi_ovf;
  logic [15:0] nxt_ctr2_cnt;
  logic nxt_ctr2_ovf;
  logic nxt_ext_event;
  logic [31:0] nxt_prdata;
  logic nxt_hit;
  logic inc0;
  logic inc0_hi;
  logic inc1;
  logic inc2;
  logic trig;
  logic split0;
  logic set_ovf0;
  logic set_ovf1;
  logic wr;
  logic [7:0] wbyte;

  // reset release through two flops
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rst_sync_ff <= 2'b00;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  tcs_phase_gen u_phase (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .c3_out(c3),
    .c4_out(c4),
    .slow_tick_out(slow_tick),
    .fast_tick_out(fast_tick)
  );

  tcs_edge_sampler #(
    .NPINS(TCS_NPINS)
  ) u_edges (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .c4_in(c4),
    .pins_in({trigger_pin_in, ctr2_count_pin_in, unit1_count_pin_in, unit0_count_pin_in}),
    .fall_out(fall)
  );

  // one step of a unit in modes 0 to 2
  function automatic tcs_cnt_t tcs_step(input tcs_mode_t mode, input logic [7:0] lo, input logic [7:0] hi);
    tcs_cnt_t r;
    r = '{lo: lo, hi: hi, ovf: 1'b0};
    unique case (mode)
      TCS_MODE_PRESCALED:
      begin
        r.lo[4:0] = lo[4:0] + 5'h1;
        if (lo[4:0] == TCS_PRESCALE_TOP)
        begin
          r.hi = hi + 8'h1;
          r.ovf = (hi == TCS_BYTE_TOP);
        end
      end
      TCS_MODE_FULL16:
      begin
        {r.hi, r.lo} = {hi, lo} + 16'h1;
        r.ovf = ({hi, lo} == TCS_WORD_TOP);
      end
      TCS_MODE_RELOAD8:
      begin
        r.lo = (lo == TCS_BYTE_TOP) ? hi : lo + 8'h1;
        r.ovf = (lo == TCS_BYTE_TOP);
      end
      TCS_MODE_SPLIT:
      begin
        r.lo = lo;
      end
    endcase
    return r;
  endfunction

  assign cfg0 = tcs_unit_cfg_t'(unit_mode_register_ff[3:0]);
  assign cfg1 = tcs_unit_cfg_t'(unit_mode_register_ff[7:4]);
  assign split0 = (cfg0.mode == TCS_MODE_SPLIT);

  // count pulses: edge from the previous cycle or the time base, all at C3
  always_comb
  begin
    logic tick0;
    logic tick1;
    logic base0;
    logic base1;
    logic run1;
    base0 = clock_select_register_ff[TCS_BIT_FAST0] ? fast_tick : slow_tick;
    base1 = clock_select_register_ff[TCS_BIT_FAST1] ? fast_tick : slow_tick;
    tick0 = cfg0.source ? (fall[TCS_PIN_U0] & c3) : base0;
    tick1 = cfg1.source ? (fall[TCS_PIN_U1] & c3) : base1;
    // unit one loses its run bit to the split high byte
    run1 = split0 ? 1'b1 : unit_control_register_ff[TCS_BIT_RUN1];
    inc0 = tick0 & unit_control_register_ff[TCS_BIT_RUN0] & (~cfg0.gate | external_gate_pin_in[0]);
    inc1 = tick1 & run1 & (~cfg1.gate | external_gate_pin_in[1]);
    inc0_hi = base0 & split0 & unit_control_register_ff[TCS_BIT_RUN1];
  end

  always_comb
  begin
    nxt_u0 = '{lo: u0_lo_ff, hi: u0_hi_ff, ovf: 1'b0};
    nxt_u0_hi_ovf = 1'b0;
    if (split0)
    begin
      if (inc0)
      begin
        nxt_u0.lo = u0_lo_ff + 8'h1;
        nxt_u0.ovf = (u0_lo_ff == TCS_BYTE_TOP);
      end
      if (inc0_hi)
      begin
        nxt_u0.hi = u0_hi_ff + 8'h1;
        nxt_u0_hi_ovf = (u0_hi_ff == TCS_BYTE_TOP);
      end
    end
    else if (inc0)
      nxt_u0 = tcs_step(cfg0.mode, u0_lo_ff, u0_hi_ff);
  end

  always_comb
  begin
    nxt_u1 = '{lo: u1_lo_ff, hi: u1_hi_ff, ovf: 1'b0};
    if (inc1)
      nxt_u1 = tcs_step(cfg1.mode, u1_lo_ff, u1_hi_ff);
  end

  assign set_ovf0 = nxt_u0.ovf;
  assign set_ovf1 = split0 ? nxt_u0_hi_ovf : nxt_u1.ovf;

  // counter two
  always_comb
  begin
    logic tick2;
    logic base2;
    base2 = clock_select_register_ff[TCS_BIT_FAST2] ? fast_tick : slow_tick;
    tick2 = ctr2_control_register_ff[TCS_BIT_C2SRC] ? (fall[TCS_PIN_C2] & c3) : base2;
    inc2 = tick2 & ctr2_control_register_ff[TCS_BIT_C2RUN];
    trig = fall[TCS_PIN_TRIG] & c3 & ctr2_control_register_ff[TCS_BIT_TRIGEN];
    nxt_ctr2_cnt = ctr2_cnt_ff;
    nxt_ctr2_ovf = 1'b0;
    nxt_ext_event = trig;
    if (inc2)
    begin
      nxt_ctr2_ovf = (ctr2_cnt_ff == TCS_WORD_TOP);
      nxt_ctr2_cnt = ctr2_cnt_ff + 16'h1;
      // up/down direction is not modelled; direction enable counts up too
      if (!ctr2_control_register_ff[TCS_BIT_CAPSEL] && nxt_ctr2_ovf)
        nxt_ctr2_cnt = capture_ff;
    end
    if (trig)
    begin
      if (ctr2_control_register_ff[TCS_BIT_CAPSEL])
      begin
        if (ctr2_mode_register_ff[TCS_BIT_AUTOCLR])
          nxt_ctr2_cnt = TCS_RST_WORD;
      end
      else
        nxt_ctr2_cnt = capture_ff;
    end
  end

  // apb: one wait state, write lands on the completing edge
  assign wr = psel_in & penable_in & pready_ff & pwrite_in;
  assign wbyte = pwdata_in[7:0];

  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    nxt_hit = 1'b1;
    unique case (paddr_in[7:0])
      TCS_OFS_UNIT_CTRL: nxt_prdata[7:0] = unit_control_register_ff;
      TCS_OFS_UNIT_MODE: nxt_prdata[7:0] = unit_mode_register_ff;
      TCS_OFS_CLK_SEL: nxt_prdata[7:0] = clock_select_register_ff;
      TCS_OFS_U0_LOW: nxt_prdata[7:0] = u0_lo_ff;
      TCS_OFS_U0_HIGH: nxt_prdata[7:0] = u0_hi_ff;
      TCS_OFS_U1_LOW: nxt_prdata[7:0] = u1_lo_ff;
      TCS_OFS_U1_HIGH: nxt_prdata[7:0] = u1_hi_ff;
      TCS_OFS_C2_CTRL: nxt_prdata[7:0] = ctr2_control_register_ff;
      TCS_OFS_C2_MODE: nxt_prdata[7:0] = ctr2_mode_register_ff;
      TCS_OFS_C2_LOW: nxt_prdata[7:0] = ctr2_cnt_ff[7:0];
      TCS_OFS_C2_HIGH: nxt_prdata[7:0] = ctr2_cnt_ff[15:8];
      TCS_OFS_CAP_LOW: nxt_prdata[7:0] = capture_ff[7:0];
      TCS_OFS_CAP_HIGH: nxt_prdata[7:0] = capture_ff[15:8];
      default: nxt_hit = 1'b0;
    endcase
    if (paddr_in[ADDR_W-1:0] != ADDR_W'(paddr_in[7:0]))
      nxt_hit = 1'b0;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= psel_in & penable_in & ~pready_ff;
      if (psel_in && penable_in && !pready_ff)
      begin
        prdata_ff <= nxt_hit ? nxt_prdata : 32'h0000_0000;
        pslverr_ff <= ~nxt_hit;
      end
      else
        pslverr_ff <= 1'b0;
    end
  end

  // unit control: hardware set beats both service clear and software write
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      unit_control_register_ff <= TCS_RST_BYTE;
    else
    begin
      if (wr && paddr_in[7:0] == TCS_OFS_UNIT_CTRL)
        unit_control_register_ff <= wbyte;
      if (set_ovf0)
        unit_control_register_ff[TCS_BIT_OVF0] <= 1'b1;
      else if (unit_int_ack_in[0])
        unit_control_register_ff[TCS_BIT_OVF0] <= 1'b0;
      if (set_ovf1)
        unit_control_register_ff[TCS_BIT_OVF1] <= 1'b1;
      else if (unit_int_ack_in[1])
        unit_control_register_ff[TCS_BIT_OVF1] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unit_mode_register_ff <= TCS_RST_BYTE;
      clock_select_register_ff <= TCS_RST_BYTE;
      ctr2_mode_register_ff <= TCS_RST_BYTE;
    end
    else if (wr)
    begin
      if (paddr_in[7:0] == TCS_OFS_UNIT_MODE)
        unit_mode_register_ff <= wbyte;
      if (paddr_in[7:0] == TCS_OFS_CLK_SEL)
        clock_select_register_ff <= wbyte;
      if (paddr_in[7:0] == TCS_OFS_C2_MODE)
        ctr2_mode_register_ff <= wbyte;
    end
  end

  // counter two flags stay until software clears them
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      ctr2_control_register_ff <= TCS_RST_BYTE;
    else
    begin
      if (wr && paddr_in[7:0] == TCS_OFS_C2_CTRL)
        ctr2_control_register_ff <= wbyte;
      if (nxt_ctr2_ovf)
        ctr2_control_register_ff[TCS_BIT_C2OVF] <= 1'b1;
      if (nxt_ext_event)
        ctr2_control_register_ff[TCS_BIT_EXTEV] <= 1'b1;
    end
  end

  // software writes to a count byte win over that cycle's increment
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      u0_lo_ff <= TCS_RST_BYTE;
      u0_hi_ff <= TCS_RST_BYTE;
      u1_lo_ff <= TCS_RST_BYTE;
      u1_hi_ff <= TCS_RST_BYTE;
    end
    else
    begin
      u0_lo_ff <= (wr && paddr_in[7:0] == TCS_OFS_U0_LOW) ? wbyte : nxt_u0.lo;
      u0_hi_ff <= (wr && paddr_in[7:0] == TCS_OFS_U0_HIGH) ? wbyte : nxt_u0.hi;
      u1_lo_ff <= (wr && paddr_in[7:0] == TCS_OFS_U1_LOW) ? wbyte : nxt_u1.lo;
      u1_hi_ff <= (wr && paddr_in[7:0] == TCS_OFS_U1_HIGH) ? wbyte : nxt_u1.hi;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      ctr2_cnt_ff <= TCS_RST_WORD;
    else
    begin
      ctr2_cnt_ff <= nxt_ctr2_cnt;
      if (wr && paddr_in[7:0] == TCS_OFS_C2_LOW)
        ctr2_cnt_ff[7:0] <= wbyte;
      if (wr && paddr_in[7:0] == TCS_OFS_C2_HIGH)
        ctr2_cnt_ff[15:8] <= wbyte;
    end
  end

  // capture takes the count as it stood before this edge's increment
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      capture_ff <= TCS_RST_WORD;
    else if (trig && ctr2_control_register_ff[TCS_BIT_CAPSEL])
      capture_ff <= ctr2_cnt_ff;
    else
    begin
      if (wr && paddr_in[7:0] == TCS_OFS_CAP_LOW)
        capture_ff[7:0] <= wbyte;
      if (wr && paddr_in[7:0] == TCS_OFS_CAP_HIGH)
        capture_ff[15:8] <= wbyte;
    end
  end

  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign unit_overflow_flag_out = {unit_control_register_ff[TCS_BIT_OVF1], unit_control_register_ff[TCS_BIT_OVF0]};
  assign ctr2_overflow_flag_out = ctr2_control_register_ff[TCS_BIT_C2OVF];
  assign external_event_flag_out = ctr2_control_register_ff[TCS_BIT_EXTEV];

endmodule // tcs_timer_counter_set

// File: tcs_pkg.sv
package tcs_pkg;

  // machine cycle timing
  localparam int TCS_CLKS_PER_MC = 4;
  localparam int TCS_CLK_PERIOD_NS = 10;
  localparam int TCS_SLOW_BASE_CLKS = 12;
  localparam logic [1:0] TCS_SLOW_DIV = 2'(TCS_SLOW_BASE_CLKS / TCS_CLKS_PER_MC);
  localparam logic [1:0] TCS_PHASE_C3 = 2'h2;
  localparam logic [1:0] TCS_PHASE_C4 = 2'h3;

  // register byte offsets
  localparam int TCS_ADDR_W = 8;
  localparam logic [7:0] TCS_OFS_UNIT_CTRL = 8'h00;
  localparam logic [7:0] TCS_OFS_UNIT_MODE = 8'h04;
  localparam logic [7:0] TCS_OFS_CLK_SEL = 8'h08;
  localparam logic [7:0] TCS_OFS_U0_LOW = 8'h0c;
  localparam logic [7:0] TCS_OFS_U0_HIGH = 8'h10;
  localparam logic [7:0] TCS_OFS_U1_LOW = 8'h14;
  localparam logic [7:0] TCS_OFS_U1_HIGH = 8'h18;
  localparam logic [7:0] TCS_OFS_C2_CTRL = 8'h1c;
  localparam logic [7:0] TCS_OFS_C2_MODE = 8'h20;
  localparam logic [7:0] TCS_OFS_C2_LOW = 8'h24;
  localparam logic [7:0] TCS_OFS_C2_HIGH = 8'h28;
  localparam logic [7:0] TCS_OFS_CAP_LOW = 8'h2c;
  localparam logic [7:0] TCS_OFS_CAP_HIGH = 8'h30;

  // unit_control_register bits
  localparam int TCS_BIT_RUN0 = 4;
  localparam int TCS_BIT_OVF0 = 5;
  localparam int TCS_BIT_RUN1 = 6;
  localparam int TCS_BIT_OVF1 = 7;
  // unit_mode_register: unit0 in [3:0], unit1 in [7:4]
  localparam int TCS_BIT_SRC0 = 2;
  localparam int TCS_BIT_SRC1 = 6;
  // clock_select_register bits
  localparam int TCS_BIT_FAST0 = 3;
  localparam int TCS_BIT_FAST1 = 4;
  localparam int TCS_BIT_FAST2 = 5;
  // ctr2_control_register bits
  localparam int TCS_BIT_CAPSEL = 0;
  localparam int TCS_BIT_C2SRC = 1;
  localparam int TCS_BIT_C2RUN = 2;
  localparam int TCS_BIT_TRIGEN = 3;
  localparam int TCS_BIT_EXTEV = 6;
  localparam int TCS_BIT_C2OVF = 7;
  // ctr2_mode_register bits
  localparam int TCS_BIT_DIREN = 0;
  localparam int TCS_BIT_AUTOCLR = 3;

  localparam logic [7:0] TCS_RST_BYTE = 8'h00;
  localparam logic [15:0] TCS_RST_WORD = 16'h0000;
  localparam logic [4:0] TCS_PRESCALE_TOP = 5'h1f;
  localparam logic [7:0] TCS_BYTE_TOP = 8'hff;
  localparam logic [15:0] TCS_WORD_TOP = 16'hffff;

  // edge sampler pin indices
  localparam int TCS_NPINS = 4;
  localparam int TCS_PIN_U0 = 0;
  localparam int TCS_PIN_U1 = 1;
  localparam int TCS_PIN_C2 = 2;
  localparam int TCS_PIN_TRIG = 3;

  typedef enum logic [1:0] {
    TCS_MODE_PRESCALED = 2'b00,
    TCS_MODE_FULL16 = 2'b01,
    TCS_MODE_RELOAD8 = 2'b10,
    TCS_MODE_SPLIT = 2'b11
  } tcs_mode_t;

  typedef struct packed {
    logic gate;
    logic source;
    tcs_mode_t mode;
  } tcs_unit_cfg_t;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic ovf;
  } tcs_cnt_t;

endpackage

// File: tcs_phase_gen.sv
`timescale 1ns/10ps
module tcs_phase_gen import tcs_pkg::*; (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // phase strobes
  output logic c3_out,
  output logic c4_out,
  output logic slow_tick_out,
  output logic fast_tick_out
);

  logic [1:0] phase_ff;
  logic [1:0] div_ff;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      phase_ff <= 2'h0;
    else
      phase_ff <= phase_ff + 2'h1;
  end

  // one in three machine cycles gives the divide-by-12 base
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      div_ff <= 2'h0;
    else if (phase_ff == TCS_PHASE_C3)
      div_ff <= (div_ff == TCS_SLOW_DIV - 2'h1) ? 2'h0 : div_ff + 2'h1;
  end

  assign c3_out = (phase_ff == TCS_PHASE_C3);
  assign c4_out = (phase_ff == TCS_PHASE_C4);
  assign fast_tick_out = c3_out;
  assign slow_tick_out = c3_out && (div_ff == 2'h0);

endmodule // tcs_phase_gen

// File: tcs_edge_sampler.sv
`timescale 1ns/10ps
module tcs_edge_sampler import tcs_pkg::*; #(
  parameter int NPINS = TCS_NPINS
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // sample strobe and pins
  input wire logic c4_in,
  input wire logic [NPINS-1:0] pins_in,
  // falling edge seen, held one machine cycle
  output logic [NPINS-1:0] fall_out
);

  logic [NPINS-1:0] smp_ff;
  logic [NPINS-1:0] fall_ff;

  genvar i;
  generate
    for (i = 0; i < NPINS; i++)
    begin : g_pin
      // reset sample low so a low pin after reset gives no false edge
      always_ff @(posedge clk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
        begin
          smp_ff[i] <= 1'b0;
          fall_ff[i] <= 1'b0;
        end
        else if (c4_in)
        begin
          smp_ff[i] <= pins_in[i];
          fall_ff[i] <= smp_ff[i] & ~pins_in[i];
        end
      end
    end
  endgenerate

  assign fall_out = fall_ff;

endmodule // tcs_edge_sampler

// File: tcs_timer_counter_set_checker.sv
`timescale 1ns/10ps
module tcs_timer_counter_set_checker import tcs_pkg::*; #(
  parameter int ADDR_W = TCS_ADDR_W
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // flags
  input wire logic [1:0] unit_int_ack_in,
  input wire logic [1:0] unit_overflow_flag_out,
  input wire logic ctr2_overflow_flag_out,
  input wire logic external_event_flag_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic wr_ctl, wr_c2;
  assign wr_ctl = pready_out && pwrite_in && paddr_in == ADDR_W'(TCS_OFS_UNIT_CTRL);
  assign wr_c2 = pready_out && pwrite_in && paddr_in == ADDR_W'(TCS_OFS_C2_CTRL);

  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready too long");
  a_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("ready late");
  a_ready_held: assert property (pready_out |-> psel_in && penable_in)
    else $error("ready without access");
  a_err_nodata: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
    else $error("bad error answer");
  a_rdata_byte: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
  a_ovf_clear: assert property ($fell(unit_overflow_flag_out[0]) |-> $past(unit_int_ack_in[0]) || $past(wr_ctl))
    else $error("unit flag lost");
  a_c2_flag_sw: assert property ($fell(ctr2_overflow_flag_out) || $fell(external_event_flag_out) |-> $past(wr_c2))
    else $error("ctr2 flag lost");
  a_ovf_spacing: assert property ($rose(unit_overflow_flag_out[1]) |=> !$rose(unit_overflow_flag_out[1]) [*3])
    else $error("flag set off phase");
endmodule // tcs_timer_counter_set_checker

bind tcs_timer_counter_set tcs_timer_counter_set_checker #(.ADDR_W(ADDR_W)) u_checker (
  .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .unit_int_ack_in(unit_int_ack_in), .unit_overflow_flag_out(unit_overflow_flag_out),
  .ctr2_overflow_flag_out(ctr2_overflow_flag_out), .external_event_flag_out(external_event_flag_out)
);

// File: tcs_pin_model.sv
`timescale 1ns/10ps
module tcs_pin_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // half period in clocks, per pin enable
  input wire logic [7:0] half_in,
  input wire logic [3:0] en_in,
  // count pins and trigger pin
  output logic [3:0] pins_out
);
  logic [7:0] cnt_ff;
  logic lvl_ff;
  logic [3:0] en_ff;
  // never faster than one level per 12 clocks
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_ff <= 8'h00;
      lvl_ff <= 1'b1;
    end
    else if (cnt_ff >= half_in - 8'h01 && cnt_ff >= 8'h0b)
    begin
      cnt_ff <= 8'h00;
      lvl_ff <= ~lvl_ff;
    end
    else
      cnt_ff <= cnt_ff + 8'h01;
  end
  // enable moves only while high, so it never fakes an edge
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      en_ff <= 4'h0;
    else if (lvl_ff)
      en_ff <= en_in;
  end
  // disabled pins rest at the pulled-up level
  assign pins_out = ~en_ff | {4{lvl_ff}};
endmodule // tcs_pin_model

// File: tcs_timer_counter_set_tb.sv
`timescale 1ns/10ps
module tcs_timer_counter_set_tb;
  import tcs_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic pready, pslverr, erv, c2flag, evflag;
  logic [7:0] paddr = 8'h00;
  logic [7:0] half = 8'h0c;
  logic [7:0] c2ctl = 8'h00;
  logic [7:0] h;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdv, rnd, w;
  logic [15:0] cap;
  logic [1:0] gate = 2'b11;
  logic [1:0] ack = 2'b00;
  logic [1:0] uflag;
  logic [3:0] pins;
  logic [3:0] pen = 4'h0;
  logic [7:0] ofs [4] = '{TCS_OFS_C2_LOW, TCS_OFS_C2_HIGH, TCS_OFS_CAP_LOW, TCS_OFS_CAP_HIGH};
  int n_mismatch = 0;
  int cmp_count = 0;
  int n;

  always #(TCS_CLK_PERIOD_NS / 2) clk = ~clk;

  tcs_timer_counter_set dut (
    .ref_clk_in(clk), .arst_n_in(arst_n), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .unit0_count_pin_in(pins[0]), .unit1_count_pin_in(pins[1]), .ctr2_count_pin_in(pins[2]),
    .trigger_pin_in(pins[3]), .external_gate_pin_in(gate), .unit_int_ack_in(ack),
    .unit_overflow_flag_out(uflag), .ctr2_overflow_flag_out(c2flag), .external_event_flag_out(evflag)
  );
  tcs_pin_model far (.clk_in(clk), .rst_n_in(arst_n), .half_in(half), .en_in(pen), .pins_out(pins));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int k;
    logic rdy;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // answer is taken settled, ahead of the edge that completes the transfer
    do
    begin
      @(negedge clk);
      rdy = pready;
      rdv = prdata;
      erv = pslverr;
      @(posedge clk);
      k++;
    end
    while (rdy !== 1'b1 && k < 20);
    if (rdy !== 1'b1)
      check(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_flag(input int i, output int k);
    logic [3:0] f;
    k = 0;
    // flags are read between edges so no launch race decides the count
    do
    begin
      @(negedge clk);
      f = {evflag, c2flag, uflag};
      k++;
    end
    while (f[i] !== 1'b1 && k < 30000);
    if (f[i] !== 1'b1)
      check(32'h0, 32'h1);
    @(posedge clk);
  endtask

  task automatic clr(input int i);
    if (i < 2)
    begin
      @(posedge clk);
      ack[i] <= 1'b1;
      @(posedge clk);
      ack <= 2'b00;
    end
    else
      apb(1'b1, TCS_OFS_C2_CTRL, c2ctl);
    @(posedge clk);
  endtask

  // clocks between two successive sets of one flag
  task automatic period(input int i, output int p);
    time t0;
    clr(i);
    wait_flag(i, p);
    t0 = $time;
    clr(i);
    wait_flag(i, p);
    p = int'(($time - t0) / TCS_CLK_PERIOD_NS);
  endtask

  initial
  begin
    rnd = $urandom(27896);
    arst_n <= 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 0; a <= 8'h34; a += 4)
    begin
      apb(1'b0, 8'(a), 8'h00);
      check(rdv, 32'h0);
      check({31'h0, erv}, {31'h0, a == 8'h34});
    end
    // timer mode 2 on both units, slow then fast base
    for (int k = 0; k < 4; k++)
    begin
      h = 8'hf0 + 8'($urandom % 14);
      apb(1'b1, TCS_OFS_UNIT_MODE, 8'h22);
      apb(1'b1, TCS_OFS_CLK_SEL, k > 1 ? 8'h18 : 8'h00);
      apb(1'b1, k[0] ? TCS_OFS_U1_HIGH : TCS_OFS_U0_HIGH, h);
      apb(1'b1, TCS_OFS_UNIT_CTRL, k[0] ? 8'h40 : 8'h10);
      period(k % 2, n);
      check(n, (256 - h) * (k > 1 ? 4 : 12));
      apb(1'b0, k[0] ? TCS_OFS_U1_HIGH : TCS_OFS_U0_HIGH, 8'h00);
      check(rdv, {24'h0, h});
    end
    // pin counting, pin period a whole number of machine cycles
    half = 8'(4 * (3 + $urandom % 3));
    for (int k = 0; k < 2; k++)
    begin
      h = 8'hf8 + 8'($urandom % 6);
      apb(1'b1, TCS_OFS_UNIT_MODE, 8'h66);
      apb(1'b1, k[0] ? TCS_OFS_U1_HIGH : TCS_OFS_U0_HIGH, h);
      apb(1'b1, TCS_OFS_UNIT_CTRL, k[0] ? 8'h40 : 8'h10);
      pen <= 4'(1 << k);
      period(k, n);
      check(n, (256 - h) * 2 * half);
    end
    pen <= 4'h0;
    gate <= 2'b10;
    apb(1'b1, TCS_OFS_CLK_SEL, 8'h08);
    apb(1'b1, TCS_OFS_UNIT_MODE, 8'h09);
    apb(1'b1, TCS_OFS_U0_LOW, 8'h00);
    apb(1'b1, TCS_OFS_UNIT_CTRL, 8'h10);
    repeat (40) @(posedge clk);
    apb(1'b0, TCS_OFS_U0_LOW, 8'h00);
    check(rdv, 32'h0);
    gate <= 2'b11;
    repeat (40) @(posedge clk);
    apb(1'b0, TCS_OFS_U0_LOW, 8'h00);
    check({31'h0, rdv >= 32'h8}, 32'h1);
    // two ticks before wrap; upper low bits must not matter in mode 0
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, TCS_OFS_UNIT_CTRL, 8'h00);
      apb(1'b1, TCS_OFS_UNIT_MODE, 8'(m));
      apb(1'b1, TCS_OFS_U0_HIGH, 8'hff);
      apb(1'b1, TCS_OFS_U0_LOW, m ? 8'hfe : 8'h3e);
      apb(1'b1, TCS_OFS_UNIT_CTRL, 8'h10);
      clr(0);
      wait_flag(0, n);
      check({31'h0, n < 16}, 32'h1);
      apb(1'b0, TCS_OFS_U0_HIGH, 8'h00);
      check(rdv, 32'h0);
    end
    // split unit zero; unit one overflows fast but must not touch its flag
    apb(1'b1, TCS_OFS_UNIT_CTRL, 8'h00);
    apb(1'b1, TCS_OFS_U0_LOW, 8'h55);
    apb(1'b1, TCS_OFS_U1_HIGH, 8'hfe);
    apb(1'b1, TCS_OFS_UNIT_MODE, 8'h23);
    apb(1'b1, TCS_OFS_UNIT_CTRL, 8'h40);
    period(1, n);
    check(n, 32'd1024);
    apb(1'b0, TCS_OFS_U0_LOW, 8'h00);
    check(rdv, 32'h55);
    apb(1'b1, TCS_OFS_UNIT_MODE, 8'h30);
    apb(1'b1, TCS_OFS_U1_LOW, 8'h5a);
    repeat (60) @(posedge clk);
    apb(1'b0, TCS_OFS_U1_LOW, 8'h00);
    check(rdv, 32'h5a);
    h = 8'hf0 + 8'($urandom % 14);
    apb(1'b1, TCS_OFS_CAP_HIGH, 8'hff);
    apb(1'b1, TCS_OFS_CAP_LOW, h);
    apb(1'b1, TCS_OFS_C2_HIGH, 8'hff);
    apb(1'b1, TCS_OFS_CLK_SEL, 8'h20);
    c2ctl = 8'h04;
    period(2, n);
    check(n, (256 - h) * 4);
    // idle pin source, so only the trigger moves the count
    apb(1'b1, TCS_OFS_C2_MODE, 8'h08);
    for (int j = 0; j < 2; j++)
    begin
      c2ctl = j ? 8'h0e : 8'h0f;
      clr(3);
      rnd = $urandom;
      apb(1'b1, TCS_OFS_C2_LOW, rnd[7:0]);
      apb(1'b1, TCS_OFS_C2_HIGH, rnd[15:8]);
      pen <= 4'h8;
      wait_flag(3, n);
      pen <= 4'h0;
      for (int b = 0; b < 4; b++)
      begin
        apb(1'b0, ofs[b], 8'h00);
        w[8*b +: 8] = rdv[7:0];
      end
      check(w, j ? {cap, cap} : {rnd[15:0], 16'h0});
      cap = rnd[15:0];
    end
    // capture mode wrap goes to zero, not to the capture value
    apb(1'b1, TCS_OFS_C2_LOW, 8'hfc);
    apb(1'b1, TCS_OFS_C2_HIGH, 8'hff);
    c2ctl = 8'h05;
    clr(2);
    wait_flag(2, n);
    check({31'h0, n < 24}, 32'h1);
    apb(1'b0, TCS_OFS_C2_HIGH, 8'h00);
    check(rdv, 32'h0);
    stop_test();
  end

  initial
  begin
    #(TCS_CLK_PERIOD_NS * 95000);
    check(32'h0, 32'h1);
    stop_test();
  end
endmodule // tcs_timer_counter_set_tb
